// *** src/era_top.sv ***
// Exception arbitration, reset sequencing and prescale timing with an AXI4-Lite register port
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Undervoltage detection sets the undervoltage bit in the reset cause register.
// - Undervoltage reset holds pin low 4096+32 cycles, then core reset 32 more.
// - Every internally generated reset drives the reset pin low.
// - Monitor entry with both reset vector bytes erased triggers monitor entry reset.
// - The prescale counter is twelve bits wide.
// - Prescale counter overflow clocks the watchdog.
// - The stop instruction clears the prescale counter.
// - Stop exit samples short recovery option: 32 cycles if set, else 4096.
// - External pin reset leaves the prescale counter untouched.
// - After any reset state the prescale counter runs freely.
// - Interrupt entry stacks core registers and sets the interrupt mask.
// - Requests are latched, arbitrated, and the vector constant handed to the core.
// - A latched interrupt holds until serviced or the mask clears.
// - At instruction end, service only if mask clear and source enabled.
// - Among several pending requests the highest priority is serviced first; the code services a latched request ahead of a higher one that arrives later.
// - A request pending at service return is serviced before the next instruction.
// - Interrupt entry does not stack the index high register.
// - Software interrupt is taken regardless of the interrupt mask.
// - Software interrupt stacks the program counter; hardware stacks counter minus one.
// - Three read-only flag registers show live requests; two low bits read zero.
// - Priority rises with vector address, flag 21 lowest, then software, then reset.
// - Resets share top priority above interrupts and bypass arbitration.
// - Every reset asserts internal reset and selects the reset or monitor vector.
// - Ordinary internal resets drive pin low 32 cycles, internal reset 32 more.
module era_top
   import era_pkg::*;
#(
   parameter logic [12:0] STAB_CYC = ERA_STAB_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic undervoltage_detector,
   input wire logic ext_rst_pin_n_in,
   output logic ext_rst_pin_out,
   output logic ext_rst_pin_oe,
   input wire logic wdog_timeout,
   input wire logic illegal_opcode,
   input wire logic illegal_address,
   input wire logic monitor_mode,
   input wire logic monitor_enter,
   input wire logic [7:0] rst_vec_hi_byte,
   input wire logic [7:0] rst_vec_lo_byte,
   input wire logic stop_exec,
   input wire logic break_req,
   input wire logic instr_done,
   input wire logic int_mask,
   input wire logic swi_exec,
   input wire logic [15:0] core_pc,
   input wire logic [ERA_NUM_IRQ-1:0] irq_req,
   input wire logic [ERA_NUM_IRQ-1:0] irq_en,
   output logic internal_reset_signal,
   output logic [15:0] reset_vector,
   output logic monitor_entry_reset,
   output logic internal_bus_clk_en,
   output logic watchdog_tick,
   output logic int_entry,
   output logic [15:0] int_vector,
   output logic [15:0] stack_pc,
   output logic set_int_mask,
   output logic push_index_high
);
   era_rst_e rst_state_r;
   era_stop_e stop_state_r;
   logic [1:0] uv_sync_r;
   logic [1:0] pin_sync_r;
   logic uv_prev_r;
   logic long_r;
   logic wrap_r;
   logic ssr_r;
   logic [5:0] ext_cnt_r;
   logic [7:0] cause_r;
   logic [7:0] ctrl_r;
   logic latched_r;
   logic [4:0] lat_idx_r;
   logic mask_prev_r;
   logic swi_ent_r;
   logic have_aw_r;
   logic have_w_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [11:0] cnt;
   logic cnt_ovf;
   logic [12:0] ext_cnt;
   logic [12:0] pin_end;
   logic uv_rise;
   logic mod_hit;
   logic int_evt;
   logic pres_clear;
   logic pres_hold;
   logic pend_any;
   logic [4:0] best_idx;
   logic [ERA_NUM_IRQ-1:0] pend;
   logic cause_rd;
   logic wr_go;
   logic [7:0] rd_word;
   logic [7:0] cause_set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         uv_sync_r <= 2'h0;
         pin_sync_r <= 2'h3;
         uv_prev_r <= 1'b0;
      end else if (clk_en) begin
         uv_sync_r <= {uv_sync_r[0], undervoltage_detector};
         pin_sync_r <= {pin_sync_r[0], ext_rst_pin_n_in};
         uv_prev_r <= uv_sync_r[1];
      end
   end

   assign uv_rise = uv_sync_r[1] && !uv_prev_r;
   assign mod_hit = monitor_enter && (rst_vec_hi_byte == ERA_ERASED) && (rst_vec_lo_byte == ERA_ERASED);
   assign int_evt = uv_rise || mod_hit || wdog_timeout || illegal_opcode || illegal_address;
   assign ext_cnt = {wrap_r, cnt};
   assign pin_end = long_r ? (STAB_CYC + ERA_SHORT_CYC - 13'h0001) : (ERA_SHORT_CYC - 13'h0001);
   assign pres_clear = (int_evt && rst_state_r != ERA_RS_PIN && rst_state_r != ERA_RS_HOLD)
                       || (stop_exec && stop_state_r == ERA_ST_RUN && rst_state_r == ERA_RS_RUN);
   assign pres_hold = stop_state_r == ERA_ST_STOP;

   era_prescaler u_prescaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .clear(pres_clear),
      .hold(pres_hold),
      .count(cnt),
      .ovf(cnt_ovf)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wrap_r <= 1'b0;
         watchdog_tick <= 1'b0;
      end else if (clk_en) begin
         watchdog_tick <= cnt_ovf;
         if (pres_clear) begin
            wrap_r <= 1'b0;
         end else if (!pres_hold && cnt == ERA_CNT_MAX) begin
            wrap_r <= 1'b1;
         end
      end
   end

   // Reset sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_state_r <= ERA_RS_PIN;
         long_r <= 1'b1;
         ext_rst_pin_oe <= 1'b1;
         ext_rst_pin_out <= 1'b0;
         internal_reset_signal <= 1'b1;
         monitor_entry_reset <= 1'b0;
         ext_cnt_r <= 6'h00;
      end else if (clk_en) begin
         ext_rst_pin_out <= 1'b0;
         monitor_entry_reset <= mod_hit;
         case (rst_state_r)
            ERA_RS_RUN, ERA_RS_EXT: begin
               if (int_evt) begin
                  rst_state_r <= ERA_RS_PIN;
                  long_r <= uv_rise;
                  ext_rst_pin_oe <= 1'b1;
                  internal_reset_signal <= 1'b1;
               end else if (!pin_sync_r[1]) begin
                  rst_state_r <= ERA_RS_EXT;
                  internal_reset_signal <= 1'b1;
                  ext_cnt_r <= 6'h00;
               end else if (rst_state_r == ERA_RS_EXT) begin
                  ext_cnt_r <= ext_cnt_r + 6'h01;
                  if (ext_cnt_r == ERA_EXT_REL_CYC - 6'h01) begin
                     rst_state_r <= ERA_RS_RUN;
                     internal_reset_signal <= 1'b0;
                  end
               end
            end
            ERA_RS_PIN: begin
               if (ext_cnt == pin_end) begin
                  rst_state_r <= ERA_RS_HOLD;
                  ext_rst_pin_oe <= 1'b0;
               end
            end
            ERA_RS_HOLD: begin
               if (ext_cnt == pin_end + ERA_SHORT_CYC) begin
                  rst_state_r <= ERA_RS_RUN;
                  internal_reset_signal <= 1'b0;
               end
            end
            default: begin
               rst_state_r <= ERA_RS_RUN;
               internal_reset_signal <= 1'b0;
               ext_rst_pin_oe <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_vector <= ERA_VEC_RESET;
      end else if (clk_en) begin
         reset_vector <= monitor_mode ? ERA_VEC_RESET_MON : ERA_VEC_RESET;
      end
   end

   // Stop mode and recovery timing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_state_r <= ERA_ST_RUN;
         internal_bus_clk_en <= 1'b1;
         ssr_r <= 1'b0;
      end else if (clk_en) begin
         if (rst_state_r != ERA_RS_RUN || int_evt) begin
            stop_state_r <= ERA_ST_RUN;
            internal_bus_clk_en <= 1'b1;
         end else begin
            case (stop_state_r)
               ERA_ST_RUN: begin
                  if (stop_exec) begin
                     stop_state_r <= ERA_ST_STOP;
                     internal_bus_clk_en <= 1'b0;
                  end
               end
               ERA_ST_STOP: begin
                  if (pend_any || break_req || !pin_sync_r[1]) begin
                     stop_state_r <= ERA_ST_REC;
                     ssr_r <= ctrl_r[ERA_CTRL_SSR_BIT];
                  end
               end
               ERA_ST_REC: begin
                  if (ext_cnt == (ssr_r ? ERA_SHORT_CYC : STAB_CYC) - 13'h0001) begin
                     stop_state_r <= ERA_ST_RUN;
                     internal_bus_clk_en <= 1'b1;
                  end
               end
               default: begin
                  stop_state_r <= ERA_ST_RUN;
                  internal_bus_clk_en <= 1'b1;
               end
            endcase
         end
      end
   end

   // Arbitration of enabled requests, lowest flag number wins
   assign pend = irq_req & irq_en;
   assign pend_any = |pend;
   always_comb begin
      best_idx = 5'h00;
      for (int i = ERA_NUM_IRQ - 1; i >= 0; i--) begin
         if (pend[i]) begin
            best_idx = 5'(i);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latched_r <= 1'b0;
         lat_idx_r <= 5'h00;
         mask_prev_r <= 1'b1;
         int_entry <= 1'b0;
         set_int_mask <= 1'b0;
         swi_ent_r <= 1'b0;
         int_vector <= ERA_VEC_SWI;
         stack_pc <= 16'h0000;
         push_index_high <= 1'b0;
      end else if (clk_en) begin
         mask_prev_r <= int_mask;
         int_entry <= 1'b0;
         set_int_mask <= 1'b0;
         push_index_high <= 1'b0;
         if (internal_reset_signal || int_evt || rst_state_r != ERA_RS_RUN) begin
            latched_r <= 1'b0;
         end else if (instr_done && swi_exec) begin
            int_entry <= 1'b1;
            set_int_mask <= 1'b1;
            swi_ent_r <= 1'b1;
            int_vector <= ERA_VEC_SWI;
            stack_pc <= core_pc;
         end else if (instr_done && !int_mask && (latched_r || pend_any) && stop_state_r == ERA_ST_RUN) begin
            int_entry <= 1'b1;
            set_int_mask <= 1'b1;
            swi_ent_r <= 1'b0;
            latched_r <= 1'b0;
            int_vector <= ERA_VEC_IF1 - {10'h000, (latched_r ? lat_idx_r : best_idx), 1'b0};
            stack_pc <= core_pc - 16'h0001;
         end else if (!int_mask && mask_prev_r) begin
            latched_r <= 1'b0;
         end else if (!int_mask && !latched_r && pend_any) begin
            latched_r <= 1'b1;
            lat_idx_r <= best_idx;
         end
      end
   end

   // Reset cause flags, set wins over the clear by read
   always_comb begin
      cause_set = 8'h00;
      cause_set[ERA_CAUSE_UV] = uv_rise;
      cause_set[ERA_CAUSE_MOD] = mod_hit;
      cause_set[ERA_CAUSE_WDOG] = wdog_timeout;
      cause_set[ERA_CAUSE_ILOP] = illegal_opcode;
      cause_set[ERA_CAUSE_ILAD] = illegal_address;
      cause_set[ERA_CAUSE_PIN] = !pin_sync_r[1] && !int_evt && rst_state_r == ERA_RS_RUN;
   end

   assign cause_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == ERA_OFS_CAUSE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_r <= ERA_CAUSE_RST;
      end else if (clk_en) begin
         cause_r <= (cause_rd ? 8'h00 : cause_r) | cause_set;
      end
   end

   // AXI4-Lite write side
   assign wr_go = have_aw_r && have_w_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_aw_r <= 1'b0;
         have_w_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ERA_RESP_OKAY;
         ctrl_r <= ERA_CTRL_RST;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            have_aw_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_w_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_r)
               ERA_OFS_CTRL: begin
                  s_axi_bresp <= ERA_RESP_OKAY;
                  if (w_strb_r[0]) begin
                     ctrl_r <= {7'h00, w_data_r[ERA_CTRL_SSR_BIT]};
                  end
               end
               ERA_OFS_FLAGS_LO, ERA_OFS_FLAGS_MID, ERA_OFS_FLAGS_HI, ERA_OFS_CAUSE: begin
                  s_axi_bresp <= ERA_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= ERA_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // AXI4-Lite read side
   always_comb begin
      case (s_axi_araddr)
         ERA_OFS_FLAGS_LO: rd_word = {irq_req[5:0], 2'b00};
         ERA_OFS_FLAGS_MID: rd_word = irq_req[13:6];
         ERA_OFS_FLAGS_HI: rd_word = {1'b0, irq_req[20:14]};
         ERA_OFS_CAUSE: rd_word = cause_r;
         ERA_OFS_CTRL: rd_word = ctrl_r;
         default: rd_word = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ERA_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_word};
            s_axi_rresp <= (s_axi_araddr > ERA_OFS_CTRL || s_axi_araddr[1:0] != 2'b00) ? ERA_RESP_SLVERR
                           : ERA_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Checks
   logic [12:0] pin_cyc_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || !ext_rst_pin_oe) begin
         pin_cyc_r <= 13'h0000;
      end else if (clk_en) begin
         pin_cyc_r <= pin_cyc_r + 13'h0001;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !clk_en);

   sequence run_evt_s;
      int_evt && rst_state_r == ERA_RS_RUN;
   endsequence
   sequence pin_drive_s;
      ext_rst_pin_oe && internal_reset_signal;
   endsequence

   pin_low_a: assert property (run_evt_s |=> pin_drive_s) else $error("internal reset did not drive pin");
   uv_flag_a: assert property (uv_rise |=> cause_r[ERA_CAUSE_UV]) else $error("undervoltage flag not set");
   pin_len_a: assert property ($fell(ext_rst_pin_oe) |-> pin_cyc_r == (long_r ? STAB_CYC + ERA_SHORT_CYC
                                                                        : ERA_SHORT_CYC))
      else $error("reset pin low time wrong");
   hold_len_a: assert property ($fell(ext_rst_pin_oe) && !long_r |-> internal_reset_signal [*8] ##25
                                 $fell(internal_reset_signal)) else $error("core reset hold wrong");
   mod_reset_a: assert property (mod_hit && rst_state_r == ERA_RS_RUN |=> monitor_entry_reset && ext_rst_pin_oe)
      else $error("monitor entry reset missing");
   wdog_tick_a: assert property (cnt == ERA_CNT_MAX && !pres_hold && !pres_clear |=> ##1 watchdog_tick)
      else $error("watchdog tick missing");
   ext_count_a: assert property (rst_state_r == ERA_RS_EXT && !pres_clear && !pres_hold |=>
                                 cnt == $past(cnt) + 12'h001) else $error("ext reset disturbed counter");
   stop_clr_a: assert property (stop_exec && pres_clear |=> cnt == 12'h000 && !internal_bus_clk_en)
      else $error("stop did not clear counter");
   swi_stack_a: assert property (instr_done && swi_exec && rst_state_r == ERA_RS_RUN && !int_evt
                                 && !internal_reset_signal |=> int_entry && stack_pc == $past(core_pc)
                                 && int_vector == ERA_VEC_SWI) else $error("software entry wrong");
   hw_entry_a: assert property (int_entry && !swi_ent_r |-> set_int_mask && !push_index_high
                                && int_vector <= ERA_VEC_IF1 && stack_pc == $past(core_pc) - 16'h0001)
      else $error("hardware entry wrong");
   mask_block_a: assert property (int_mask && !swi_exec |=> !int_entry) else $error("masked entry taken");
endmodule : era_top

// *** src/era_pkg.sv ***
// Constants shared by the exception and reset arbiter
package era_pkg;
   localparam int ERA_CNT_W = 12;
   localparam int ERA_EXT_W = 13;
   localparam int ERA_NUM_IRQ = 21;
   localparam logic [12:0] ERA_STAB_CYC = 13'h1000;
   localparam logic [12:0] ERA_SHORT_CYC = 13'h0020;
   localparam logic [11:0] ERA_CNT_MAX = 12'hfff;
   localparam logic [5:0] ERA_EXT_REL_CYC = 6'h20;
   localparam logic [15:0] ERA_VEC_RESET = 16'hfffe;
   localparam logic [15:0] ERA_VEC_RESET_MON = 16'hfefe;
   localparam logic [15:0] ERA_VEC_SWI = 16'hfffc;
   localparam logic [15:0] ERA_VEC_IF1 = 16'hfffa;
   localparam logic [7:0] ERA_ERASED = 8'hff;
   localparam logic [7:0] ERA_OFS_FLAGS_LO = 8'h00;
   localparam logic [7:0] ERA_OFS_FLAGS_MID = 8'h04;
   localparam logic [7:0] ERA_OFS_FLAGS_HI = 8'h08;
   localparam logic [7:0] ERA_OFS_CAUSE = 8'h0c;
   localparam logic [7:0] ERA_OFS_CTRL = 8'h10;
   localparam int ERA_CTRL_SSR_BIT = 0;
   localparam logic [7:0] ERA_CTRL_RST = 8'h00;
   localparam int ERA_CAUSE_POR = 7;
   localparam int ERA_CAUSE_PIN = 6;
   localparam int ERA_CAUSE_WDOG = 5;
   localparam int ERA_CAUSE_ILOP = 4;
   localparam int ERA_CAUSE_ILAD = 3;
   localparam int ERA_CAUSE_MOD = 2;
   localparam int ERA_CAUSE_UV = 1;
   localparam logic [7:0] ERA_CAUSE_RST = 8'h80;
   localparam logic [1:0] ERA_RESP_OKAY = 2'h0;
   localparam logic [1:0] ERA_RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      ERA_RS_RUN = 4'h1,
      ERA_RS_PIN = 4'h2,
      ERA_RS_HOLD = 4'h4,
      ERA_RS_EXT = 4'h8
   } era_rst_e;
   typedef enum logic [2:0] {
      ERA_ST_RUN = 3'h1,
      ERA_ST_STOP = 3'h2,
      ERA_ST_REC = 3'h4
   } era_stop_e;
endpackage : era_pkg

// *** src/era_prescaler.sv ***
// Twelve-bit free-running prescale counter with clear, hold and overflow pulse
`timescale 1ns/1ps
module era_prescaler
   import era_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic clear,
   input wire logic hold,
   output logic [ERA_CNT_W-1:0] count,
   output logic ovf
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else if (clk_en) begin
         if (clear) begin
            count <= '0;
         end else if (!hold) begin
            count <= count + 12'h001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf <= 1'b0;
      end else if (clk_en) begin
         ovf <= !clear && !hold && (count == ERA_CNT_MAX);
      end
   end
endmodule : era_prescaler

// *** sim/era_core_model.sv ***
// Behavioural core: completes instructions on request and tracks the interrupt mask
`timescale 1ns/1ps
module era_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic step,
   input wire logic software_interrupt_instr,
   input wire logic sei,
   input wire logic return_from_interrupt,
   input wire logic set_int_mask,
   output logic instr_done,
   output logic swi_exec,
   output logic [15:0] core_pc,
   output logic int_mask
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_done <= 1'b0;
         swi_exec <= 1'b0;
         core_pc <= 16'h8000;
         int_mask <= 1'b0;
      end else begin
         instr_done <= step;
         swi_exec <= step & software_interrupt_instr;
         if (instr_done) core_pc <= core_pc + 16'h0003;
         // Mask set on entry, cleared by return
         if (set_int_mask || sei) int_mask <= 1'b1;
         else if (return_from_interrupt) int_mask <= 1'b0;
      end
   end
endmodule : era_core_model

// *** sim/testbench.sv ***
// Self-checking bench for the exception and reset arbiter
`timescale 1ns/1ps
module testbench;
   import era_pkg::*;
   localparam logic [12:0] STAB = 13'h0040;
   logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, monitor_mode = 1'b0, step = 1'b0, software_interrupt_instr = 1'b0, sei = 1'b0;
   logic return_from_interrupt = 1'b0, pin_n = 1'b1, msk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic ext_rst_pin_out, ext_rst_pin_oe, internal_reset_signal, monitor_entry_reset, internal_bus_clk_en;
   logic watchdog_tick, int_entry, set_int_mask, push_index_high, instr_done, swi_exec, int_mask;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, vb = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d, seed = 32'hf1d7, r1, r2;
   logic [4:0] ev = 5'h00;
   logic [20:0] irq_req = '0, irq_en = '0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] reset_vector, int_vector, stack_pc, core_pc, pc, v;
   int n_fail = 0, check_count = 0, n_tick = 0, cb[5] = '{ERA_CAUSE_UV, ERA_CAUSE_WDOG, ERA_CAUSE_ILOP,
      ERA_CAUSE_ILAD, ERA_CAUSE_MOD};
   era_top #(.STAB_CYC(STAB)) uut (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .undervoltage_detector(ev[0]), .ext_rst_pin_n_in(pin_n), .ext_rst_pin_out, .ext_rst_pin_oe,
      .wdog_timeout(ev[1]), .illegal_opcode(ev[2]), .illegal_address(ev[3]), .monitor_mode,
      .monitor_enter(ev[4]), .rst_vec_hi_byte(vb), .rst_vec_lo_byte(vb), .stop_exec(1'b0), .break_req(1'b0),
      .instr_done, .int_mask, .swi_exec, .core_pc, .irq_req, .irq_en, .internal_reset_signal, .reset_vector,
      .monitor_entry_reset, .internal_bus_clk_en, .watchdog_tick, .int_entry, .int_vector, .stack_pc,
      .set_int_mask, .push_index_high);
   era_core_model core (.aclk, .aresetn, .step, .software_interrupt_instr, .sei, .return_from_interrupt, .set_int_mask, .instr_done, .swi_exec,
      .core_pc, .int_mask);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) if (watchdog_tick) n_tick <= n_tick + 1;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [15:0] exp_vec(input logic s, input logic m, input logic [20:0] p);
      if (s) return ERA_VEC_SWI;
      if (!m) for (int i = 0; i < 21; i++) if (p[i]) return ERA_VEC_IF1 - 16'(2 * i);
      return 16'h0000;
   endfunction : exp_vec
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   // Times pin drive and the core reset tail of one reset sequence
   task automatic seq(input int n_pin, input logic [15:0] vec);
      int n, m;
      n = 0;
      m = 0;
      repeat (10) if (!ext_rst_pin_oe) @(posedge aclk);
      while (ext_rst_pin_oe && n < 9000) begin
         n++;
         @(posedge aclk);
      end
      check("reset vector", vec, reset_vector);
      while (internal_reset_signal && m < 200) begin
         m++;
         @(posedge aclk);
      end
      if (n_pin > 0) check("pin low cycles", n_pin, n);
      check("core reset tail", 32, m);
   endtask : seq
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (40000) @(posedge aclk);
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      seq(0, ERA_VEC_RESET);
      rd(ERA_OFS_CAUSE, rd_d, rsp);
      check("cause after power-on", 32'h80, rd_d);
      for (int k = 0; k < 5; k++) begin
         monitor_mode <= (k == 4);
         vb <= (k == 4) ? ERA_ERASED : 8'h7f;
         @(posedge aclk);
         ev <= (5'h01 << k) | ((k == 1) ? 5'h10 : 5'h00);
         @(posedge aclk);
         ev <= 5'h00;
         seq((k == 0) ? int'(STAB) + 32 : 32, (k == 4) ? ERA_VEC_RESET_MON : ERA_VEC_RESET);
         monitor_mode <= 1'b0;
         rd(ERA_OFS_CAUSE, rd_d, rsp);
         check("reset cause", 32'h1 << cb[k], rd_d);
      end
      $display("reset sources done");
      irq_req <= 21'(rnd());
      @(posedge aclk);
      rd(ERA_OFS_FLAGS_LO, rd_d, rsp);
      check("flags low", {24'h0, irq_req[5:0], 2'b00}, rd_d);
      rd(ERA_OFS_FLAGS_MID, rd_d, rsp);
      check("flags mid", {24'h0, irq_req[13:6]}, rd_d);
      rd(ERA_OFS_FLAGS_HI, rd_d, rsp);
      check("flags high", {25'h0, irq_req[20:14]}, rd_d);
      rd(8'h14, rd_d, rsp);
      check("unmapped data", 32'h0, rd_d);
      check("unmapped resp", ERA_RESP_SLVERR, rsp);
      wr(ERA_OFS_FLAGS_LO, 32'hff, rsp);
      check("flag write resp", ERA_RESP_OKAY, rsp);
      wr(8'h20, 32'h1, rsp);
      check("unmapped write", ERA_RESP_SLVERR, rsp);
      wr(ERA_OFS_CTRL, 32'h1, rsp);
      rd(ERA_OFS_CTRL, rd_d, rsp);
      check("ctrl readback", 32'h1, rd_d);
      $display("registers done");
      n_tick = 0;
      repeat (8192) @(posedge aclk);
      check("watchdog ticks", 2, n_tick);
      for (int i = 0; i < 32; i++) begin
         r1 = rnd();
         r2 = rnd();
         msk = (r2[29:27] == 3'h0);
         irq_req <= 21'(r1 >> r2[4:0]);
         irq_en <= ~21'(rnd() & rnd());
         software_interrupt_instr <= (r2[31:30] == 2'h0);
         sei <= msk;
         @(posedge aclk);
         {sei, step} <= 2'h1;
         @(posedge aclk);
         step <= 1'b0;
         @(posedge aclk);
         pc = core_pc;
         v = exp_vec(software_interrupt_instr, msk, irq_req & irq_en);
         @(posedge aclk);
         check("int entry", v != 16'h0, int_entry);
         if (v != 16'h0) begin
            check("int vector", v, int_vector);
            check("stacked pc", software_interrupt_instr ? pc : pc - 16'h1, stack_pc);
            check("mask set", 1'b1, set_int_mask);
            check("index high kept", 1'b0, push_index_high);
         end
         irq_req <= '0;
         return_from_interrupt <= 1'b1;
         @(posedge aclk);
         return_from_interrupt <= 1'b0;
         @(posedge aclk);
      end
      $display("interrupts done");
      pin_n <= 1'b0;
      repeat (6) @(posedge aclk);
      check("pin reset held", 1, internal_reset_signal);
      pin_n <= 1'b1;
      repeat (60) @(posedge aclk);
      check("pin reset end", 0, internal_reset_signal);
      $display("pin reset done");
      give_verdict();
   end
endmodule : testbench
